// ### src/wdt_pkg.sv
// constants shared by the windowed watchdog design
package wdt_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CNT_W         = 17;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned WIN_W         = 2;
  localparam int unsigned BASE_EXP      = 10;
  // register offsets
  localparam logic [7:0]  OPTION_OFFS   = 8'h80;
  localparam logic [7:0]  RESTART_OFFS  = 8'h81;
  localparam logic [7:0]  OSC_MODE_OFFS = 8'h82;
  localparam logic [7:0]  STATUS_OFFS   = 8'h83;
  localparam logic [7:0]  MASK_OFFS     = 8'h84;
  localparam logic [7:0]  CNT_LO_OFFS   = 8'h85;
  localparam logic [7:0]  CNT_MID_OFFS  = 8'h86;
  localparam logic [7:0]  CNT_HI_OFFS   = 8'h87;
  // option byte fields
  localparam int unsigned OPT_KEEP_BIT  = 0;
  localparam int unsigned OPT_SEL_LSB   = 1;
  localparam int unsigned OPT_WIN_LSB   = 5;
  localparam logic [7:0]  OPTION_RST    = 8'h0e;
  // oscillator mode register field
  localparam int unsigned OSC_STOP_BIT  = 1;
  // restart key
  localparam logic [7:0]  RESTART_KEY   = 8'hac;
  // status bits
  localparam int unsigned NUM_EVT       = 3;
  localparam int unsigned EVT_RESTART   = 0;
  localparam int unsigned EVT_BAD_WR    = 1;
  localparam int unsigned EVT_OVERFLOW  = 2;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  typedef enum logic [1:0] {WDT_WIN_25, WDT_WIN_50, WDT_WIN_75, WDT_WIN_100} wdt_win_t;
endpackage

// ### src/wdt_sync.sv
// two-stage synchroniser with rising-edge pulse
`timescale 1ns/10ps
module wdt_sync
  import wdt_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  // next values: only the second stage feeds the edge detector
  always_comb begin
    meta_next  = async_in;
    sync_next  = meta_reg;
    last_next  = sync_reg;
    rise_pulse = sync_reg & ~last_reg;
  end

  // stage registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end
endmodule

// ### src/wdt_limit.sv
// overflow and window-open thresholds from the option fields
`timescale 1ns/10ps
module wdt_limit
  import wdt_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic [SEL_W-1:0] overflow_sel,
  input  wire logic [WIN_W-1:0] window_size,
  output logic [CW-1:0]         last_count,
  output logic [CW-1:0]         open_from
);
  logic [CW:0]   period;
  logic [CW-1:0] quarter;
  logic [1:0]    closed_q;

  // period doubles per select step, open part counted in quarters
  always_comb begin
    period     = (CW+1)'(1) << (BASE_EXP + int'(overflow_sel));
    last_count = CW'(period - (CW+1)'(1));
    quarter    = CW'(period >> 2);
    closed_q   = 2'(3 - int'(window_size));
    open_from  = CW'(quarter * closed_q);
  end
endmodule

// ### src/wdt_top.sv
// windowed watchdog timer: counter, window check, registers, interrupt
//
// Functional notes
// - overflow select from option byte bits 3..1
// - overflow without restart raises internal reset
// - key 0xac in open window restarts count
// - select codes give 2^10..2^17 oscillator cycles
// - counting continues during flash self-programming
// - open window 25/50/75/100 percent, closed first
// - count on low-speed oscillator clock rising edges
// - keep option 0 halts count in halt/stop
// - oscillator stop with keep 0 freezes count
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              low_speed_osc_clock,
  input  wire logic              halt_mode,
  input  wire logic              stop_mode,
  input  wire logic              flash_busy,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   wdt_reset_out,
  output logic                   window_open_out,
  output logic                   irq
);
  // tick and thresholds
  logic              osc_tick;
  logic [CW-1:0]     last_count;
  logic [CW-1:0]     open_from;

  // register state and next values
  logic [DATA_W-1:0] option_reg;
  logic [DATA_W-1:0] option_next;
  logic [DATA_W-1:0] osc_mode_reg;
  logic [DATA_W-1:0] osc_mode_next;
  logic [CW-1:0]     cnt_reg;
  logic [CW-1:0]     cnt_next;
  logic [NUM_EVT-1:0] status_reg;
  logic [NUM_EVT-1:0] status_next;
  logic [NUM_EVT-1:0] mask_reg;
  logic [NUM_EVT-1:0] mask_next;
  // output flops and next values
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              reset_reg;
  logic              reset_next;
  logic              open_reg;
  logic              open_next;
  logic              irq_reg;
  logic              irq_next;

  // decoded option and oscillator mode fields
  logic [SEL_W-1:0]  overflow_sel;
  logic [WIN_W-1:0]  window_size;
  logic              low_speed_osc_keep_on;
  logic              low_speed_osc_stop;
  // counting, window and event terms
  logic              count_enable;
  logic              window_is_open;
  logic              key_write;
  logic              good_restart;
  logic              bad_write;
  logic              overflow;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] clr;

  // counter bytes as seen on the byte-wide read port
  localparam int unsigned CNT_BYTES = (CW + DATA_W - 1) / DATA_W;
  localparam int unsigned BYTE_LO   = 0;
  localparam int unsigned BYTE_MID  = 1;
  localparam int unsigned BYTE_HI   = 2;
  logic [CNT_BYTES*DATA_W-1:0] cnt_wide;
  logic [DATA_W-1:0]           cnt_byte [CNT_BYTES];

  // oscillator edges cross into the system clock
  // oscillator edge tick
  wdt_sync u_osc_sync (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .async_in   (low_speed_osc_clock),
    .rise_pulse (osc_tick)
  );

  // thresholds for the selected period and window
  // period from select code
  wdt_limit #(
    .CW (CW)
  ) u_limit (
    .overflow_sel (overflow_sel),
    .window_size  (window_size),
    .last_count   (last_count),
    .open_from    (open_from)
  );

  // option byte and oscillator mode fields
  always_comb begin
    overflow_sel          = option_reg[OPT_SEL_LSB +: SEL_W];
    window_size           = option_reg[OPT_WIN_LSB +: WIN_W];
    low_speed_osc_keep_on = option_reg[OPT_KEEP_BIT];
    low_speed_osc_stop    = osc_mode_reg[OSC_STOP_BIT];
  end

  // counting gate for power modes and stopped oscillator
  always_comb begin
    // tick counts unless a pause source holds it
    count_enable = osc_tick;
    if (!low_speed_osc_keep_on && (halt_mode || stop_mode)) begin
      count_enable = 1'b0;
    end
    if (!low_speed_osc_keep_on && low_speed_osc_stop) begin
      count_enable = 1'b0;
    end
    // flash activity never gates the count
    if (flash_busy && low_speed_osc_keep_on) begin
      count_enable = count_enable | osc_tick;
    end
  end

  // window state from the running count
  always_comb begin
    window_is_open = (window_size == WDT_WIN_100) || (cnt_reg >= open_from);
  end

  // restart decode and overflow detect
  always_comb begin
    key_write      = reg_wr && (reg_addr == RESTART_OFFS);
    good_restart   = key_write && (reg_wdata == RESTART_KEY) && window_is_open;
    bad_write      = key_write && !good_restart;
    // overflow at or past last count with tick
    overflow       = count_enable && (cnt_reg >= last_count) && !good_restart;
  end

  // counter next value
  always_comb begin
    cnt_next = cnt_reg;
    if (good_restart || overflow) begin
      cnt_next = '0;
    end else if (count_enable) begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  // software writable registers
  always_comb begin
    option_next   = option_reg;
    osc_mode_next = osc_mode_reg;
    mask_next     = mask_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        OPTION_OFFS:   option_next   = reg_wdata;
        OSC_MODE_OFFS: osc_mode_next = reg_wdata;
        MASK_OFFS:     mask_next     = reg_wdata[NUM_EVT-1:0];
        default:       option_next   = option_reg;
      endcase
    end
  end

  // sticky status, write one to clear, set beats clear
  always_comb begin
    evt[EVT_RESTART]  = good_restart;
    evt[EVT_BAD_WR]   = bad_write;
    evt[EVT_OVERFLOW] = overflow;
    clr               = '0;
    if (reg_wr && (reg_addr == STATUS_OFFS)) begin
      clr = reg_wdata[NUM_EVT-1:0];
    end
  end

  // sticky flags, one per event
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_evt
      // one sticky flag per event
      always_comb begin
        status_next[gi] = evt[gi] | (status_reg[gi] & ~clr[gi]);
      end
    end
  endgenerate

  // count padded to whole bytes
  always_comb begin
    cnt_wide = (CNT_BYTES*DATA_W)'(cnt_reg);
  end

  // one read slice per counter byte
  genvar bi;
  generate
    for (bi = 0; bi < CNT_BYTES; bi = bi + 1) begin : g_cnt_byte
      always_comb begin
        cnt_byte[bi] = cnt_wide[bi*DATA_W +: DATA_W];
      end
    end
  endgenerate

  // read data, answered in the cycle after the strobe
  always_comb begin
    rdata_next = ZERO_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        OPTION_OFFS:   rdata_next = option_reg;
        OSC_MODE_OFFS: rdata_next = osc_mode_reg;
        STATUS_OFFS:   rdata_next = DATA_W'(status_reg);
        MASK_OFFS:     rdata_next = DATA_W'(mask_reg);
        CNT_LO_OFFS:   rdata_next = cnt_byte[BYTE_LO];
        CNT_MID_OFFS:  rdata_next = cnt_byte[BYTE_MID];
        CNT_HI_OFFS:   rdata_next = cnt_byte[BYTE_HI];
        default:       rdata_next = ZERO_BYTE;
      endcase
    end
  end

  // internal reset request one cycle after overflow
  always_comb begin
    reset_next = overflow;
  end

  // window flag tracks the count it will sit beside
  always_comb begin
    open_next = (window_size == WDT_WIN_100) || (cnt_next >= open_from);
  end

  // level interrupt from unmasked sticky flags
  always_comb begin
    irq_next = |(status_next & mask_next);
  end

  // counter register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // option byte and oscillator mode registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      option_reg   <= OPTION_RST;
      osc_mode_reg <= ZERO_BYTE;
    end else begin
      option_reg   <= option_next;
      osc_mode_reg <= osc_mode_next;
    end
  end

  // sticky status and mask registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_reg <= '0;
      mask_reg   <= '0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  // read data register, zero outside a read answer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // output flags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reset_reg <= 1'b0;
      open_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      reset_reg <= reset_next;
      open_reg  <= open_next;
      irq_reg   <= irq_next;
    end
  end

  // port drive
  assign reg_rdata       = rdata_reg;
  assign wdt_reset_out   = reset_reg;
  assign window_open_out = open_reg;
  assign irq             = irq_reg;
endmodule

// ### tb/wdt_top_chk.sv
// port checker for the windowed watchdog
`timescale 1ns/10ps
module wdt_top_chk
  import wdt_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic              halt_mode,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              wdt_reset_out,
  input wire logic              window_open_out,
  input wire logic              irq
);
  logic [7:0] opt_reg;
  logic [7:0] mask_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // shadow of option and mask writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opt_reg  <= OPTION_RST;
      mask_reg <= ZERO_BYTE;
    end else if (reg_wr && reg_addr == OPTION_OFFS) begin
      opt_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == MASK_OFFS) begin
      mask_reg <= reg_wdata;
    end
  end
  chk_pulse_short: assert property (wdt_reset_out |=> (!wdt_reset_out)[*8])
    else $error("reset pulse too long");
  chk_ovf_closed: assert property (
    wdt_reset_out && opt_reg[6:5] != 2'b11 |-> !window_open_out) else $error("open at overflow");
  chk_ovf_irq: assert property (
    wdt_reset_out && mask_reg[EVT_OVERFLOW] |=> irq) else $error("no overflow irq");
  chk_full_open: assert property (reg_wr && reg_addr == OPTION_OFFS &&
    reg_wdata[6:5] == 2'b11 |-> ##[1:3] window_open_out) else $error("full window shut");
  chk_restart_shut: assert property (reg_wr && reg_addr == RESTART_OFFS &&
    reg_wdata == RESTART_KEY && window_open_out && opt_reg[6:5] != 2'b11
    |-> ##[1:2] !window_open_out) else $error("restart kept window open");
  chk_halt_freeze: assert property (
    (halt_mode && !opt_reg[OPT_KEEP_BIT])[*8] |-> !wdt_reset_out) else $error("overflow in halt");
  chk_rd_option: assert property (
    reg_rd && reg_addr == OPTION_OFFS |=> reg_rdata == opt_reg) else $error("option readback");
  chk_mask_off: assert property (
    reg_wr && reg_addr == MASK_OFFS && reg_wdata == ZERO_BYTE |-> ##2 !irq) else $error("irq");
endmodule
bind wdt_top wdt_top_chk #(.CW(CW)) u_chk (.clk_sys(clk_sys), .srst(srst),
  .halt_mode(halt_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset_out(wdt_reset_out),
  .window_open_out(window_open_out), .irq(irq));

// ### tb/wdt_top_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module wdt_top_tb_top
  import wdt_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       low_speed_osc_clock = 1'b0;
  logic       halt_mode = 1'b0;
  logic       stop_mode = 1'b0;
  logic       flash_busy = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       wdt_reset_out;
  logic       window_open_out;
  logic       irq;
  logic [1:0] div = 2'b00;
  logic [7:0] snap;
  logic [7:0] held;
  int         bad_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  int         n;
  wdt_top #(.CW(CNT_W)) u_dut (.clk_sys(clk_sys), .srst(srst),
    .low_speed_osc_clock(low_speed_osc_clock), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .flash_busy(flash_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset_out(wdt_reset_out),
    .window_open_out(window_open_out), .irq(irq));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // oscillator at a quarter of clk_sys, and run limit
  always @(posedge clk_sys) begin
    div <= div + 2'd1;
    low_speed_osc_clock <= div[1];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic peek(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 snap = reg_rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    peek(a);
    chk("rdata", exp, snap);
  endtask
  // two overflows apart under one select code
  task automatic period_chk(input logic [7:0] opt);
    wr(OPTION_OFFS, opt);
    @(posedge clk_sys iff wdt_reset_out === 1'b1);
    n = cyc;
    @(posedge clk_sys iff wdt_reset_out === 1'b1);
    chk("period", (32'd1024 << opt[3:1]) * 4, cyc - n);
  endtask
  task automatic tally_and_finish();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OPTION_OFFS, OPTION_RST);
    rd(8'h90, 8'h00);
    chk("window", 0, window_open_out);
    wr(RESTART_OFFS, RESTART_KEY);
    rd(STATUS_OFFS, 8'h02);
    wr(STATUS_OFFS, 8'h02);
    wr(MASK_OFFS, 8'h07);
    wr(OPTION_OFFS, 8'h20);
    @(posedge clk_sys iff window_open_out === 1'b1);
    rd(CNT_MID_OFFS, 8'h02);
    wr(RESTART_OFFS, RESTART_KEY);
    rd(STATUS_OFFS, 8'h01);
    rd(CNT_MID_OFFS, 8'h00);
    chk("irq", 1, irq);
    // each pause source freezes the count
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      halt_mode <= (i == 0);
      stop_mode <= (i == 1);
      if (i == 2) wr(OSC_MODE_OFFS, 8'h02);
      repeat (8) @(posedge clk_sys);
      peek(CNT_LO_OFFS);
      held = snap;
      repeat (40) @(posedge clk_sys);
      rd(CNT_LO_OFFS, held);
      @(posedge clk_sys);
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
      wr(OSC_MODE_OFFS, 8'h00);
    end
    flash_busy <= 1'b1;
    wr(STATUS_OFFS, 8'h07);
    @(posedge clk_sys iff wdt_reset_out === 1'b1);
    repeat (2) @(posedge clk_sys);
    chk("irq", 1, irq);
    rd(STATUS_OFFS, 8'h04);
    period_chk(8'h20);
    period_chk(8'h22);
    wr(OPTION_OFFS, 8'h60);
    repeat (3) @(posedge clk_sys);
    chk("window", 1, window_open_out);
    wr(STATUS_OFFS, 8'h07);
    wr(RESTART_OFFS, RESTART_KEY);
    rd(STATUS_OFFS, 8'h01);
    // keep option set: halt no longer freezes the count
    wr(OPTION_OFFS, 8'h61);
    halt_mode <= 1'b1;
    peek(CNT_LO_OFFS);
    held = snap;
    repeat (40) @(posedge clk_sys);
    peek(CNT_LO_OFFS);
    chk("keep", 1, snap != held);
    halt_mode <= 1'b0;
    wr(MASK_OFFS, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq", 0, irq);
    tally_and_finish();
  end
endmodule
